// ===== rtl/scirq_top.sv
// Smart card interrupt cause and mask registers with their Avalon-MM slave.
// Assumes event inputs are synchronous to clk and that the master keeps its
// request steady until it sees waitrequest low.
`timescale 1ns/1ns
`default_nettype none

module scirq_top
   import scirq_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [SCIRQ_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire scirq_evt_t evt_int,
   input wire scirq_evt_t evt_ext,
   input wire logic logic_clk_gated,
   input wire logic power_down_bit,
   output logic card_irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   scirq_state_t s_q;
   scirq_state_t s_d;
   scirq_evt_t ev;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [15:0] idx;
   logic req;
   logic take;
   logic live;
   logic clk_fall;
   logic len_done;

   assign idx = avs_address[SCIRQ_ADDR_W-1:2];
   assign req = avs_read | avs_write;
   assign take = req & ~s_q.wreq;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      set_v = 8'h00;
      clr_v = 8'h00;
      clk_fall = 1'b0;
      len_done = 1'b0;

      // Interface choice; unselected interfaces never reach the cause bits
      case (s_q.sel)
         SCIRQ_SEL_NONE: ev = '0;
         SCIRQ_SEL_EXT: ev = evt_ext;
         default: ev = evt_int;
      endcase

      // Everything but card events stops while the logic clock is off
      live = ~logic_clk_gated & ~power_down_bit;

      s_d.clk_prev = ev.card_clk;
      s_d.dat_prev = ev.card_data;
      s_d.txe_prev = ev.tx_fifo_empty;
      s_d.txf_prev = ev.tx_fifo_full;
      s_d.brk_prev = ev.break_detected;
      s_d.und_prev = ev.tx_underrun;

      // Length counter on falling card clock; a zero load never runs
      clk_fall = s_q.clk_prev & ~ev.card_clk;
      if (s_q.len_run && s_q.sync && clk_fall && live) begin
         s_d.len_cnt = s_q.len_cnt + 8'h01;
         if (s_q.len_cnt + 8'h01 == s_q.len_load) begin
            len_done = 1'b1;
            s_d.len_run = 1'b0;
         end
      end

      // Event sources for each cause bit
      if (s_q.sync) begin
         set_v[SCIRQ_B_TIMEOUT] = len_done;
      end else begin
         set_v[SCIRQ_B_TIMEOUT] = ev.wait_timeout & live;
      end
      set_v[SCIRQ_B_CARD] = ev.card_detect_pin | ev.fault;
      set_v[SCIRQ_B_SUPPLY] = ev.supply_stable_timer & live;
      if (s_q.bypass) begin
         set_v[SCIRQ_B_RXAV] = s_q.dat_prev & ~ev.card_data & live;
      end else begin
         set_v[SCIRQ_B_RXAV] = ev.rx_not_empty & live;
      end
      set_v[SCIRQ_B_TXEVT] = live & ((ev.tx_fifo_empty & ~s_q.txe_prev) |
                             (ev.tx_fifo_full & ~s_q.txf_prev));
      set_v[SCIRQ_B_TXDONE] = live & ((ev.byte_sent &
                              ~(s_q.t0 & s_q.brk_en & ev.break_at_end)) |
                              ev.check_sent);
      set_v[SCIRQ_B_TX_ERROR_FLAG] = live & ((ev.break_detected & ~s_q.brk_prev) |
                             (ev.tx_underrun & ~s_q.und_prev));
      set_v[SCIRQ_B_RX_ERROR_FLAG] = live & (ev.rx_overrun | ev.rx_parity);

      // Clears; a cause read clears only the bits it actually returned
      if (take && avs_read) begin
         case (idx)
            SCIRQ_IDX_CAUSE: begin
               clr_v = s_q.rdata[7:0] & (SCIRQ_CAUSE_RDCLR |
                       (s_q.bypass ? SCIRQ_BYPASS_RDCLR : 8'h00));
            end
            SCIRQ_IDX_TXCTL: clr_v = SCIRQ_TXCTL_CLR;
            SCIRQ_IDX_RXCTL: clr_v = SCIRQ_RXCTL_CLR;
            default: clr_v = 8'h00;
         endcase
      end
      // Outside bypass the rx bit is a plain level of the FIFO state
      if (!s_q.bypass && !(ev.rx_not_empty & live)) begin
         clr_v[SCIRQ_B_RXAV] = 1'b1;
      end
      s_d.cause = (s_q.cause & ~clr_v) | set_v;

      // Register writes take effect on the accepting edge
      if (take && avs_write) begin
         case (idx)
            SCIRQ_IDX_SELECT: begin
               s_d.sel = avs_writedata[SCIRQ_SEL_LSB+1:SCIRQ_SEL_LSB];
               s_d.bypass = avs_writedata[SCIRQ_BYPASS_BIT];
            end
            SCIRQ_IDX_MASK: s_d.mask = avs_writedata[7:0];
            SCIRQ_IDX_MODE: begin
               s_d.sync = avs_writedata[SCIRQ_MODE_SYNC];
               s_d.t0 = avs_writedata[SCIRQ_MODE_T0];
               s_d.brk_en = avs_writedata[SCIRQ_MODE_BRKEN];
            end
            SCIRQ_IDX_LENGTH: begin
               s_d.len_load = avs_writedata[7:0];
               s_d.len_cnt = 8'h00;
               s_d.len_run = (avs_writedata[7:0] != 8'h00);
            end
            default: begin
            end
         endcase
      end

      // One wait cycle, then the answer; read data is caught first
      s_d.wreq = ~(req & s_q.wreq);
      if (req && s_q.wreq && avs_read) begin
         case (idx)
            SCIRQ_IDX_SELECT: begin
               s_d.rdata = {28'h0000000, s_q.sel, s_q.bypass, 1'b0};
            end
            SCIRQ_IDX_CAUSE: s_d.rdata = {24'h000000, s_q.cause};
            SCIRQ_IDX_MASK: s_d.rdata = {24'h000000, s_q.mask};
            SCIRQ_IDX_MODE: s_d.rdata = {29'h00000000, s_q.brk_en, s_q.t0, s_q.sync};
            SCIRQ_IDX_LENGTH: s_d.rdata = {15'h0000, s_q.len_run, s_q.len_cnt, s_q.len_load};
            SCIRQ_IDX_TXCTL: begin
               s_d.rdata = {28'h0000000, ev.tx_fifo_empty, ev.tx_fifo_full,
                            ev.break_detected, ev.tx_underrun};
            end
            SCIRQ_IDX_RXCTL: s_d.rdata = {30'h00000000, ev.rx_overrun, ev.rx_parity};
            default: s_d.rdata = 32'h00000000;
         endcase
      end

      s_d.irq = |(s_d.cause & s_d.mask);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= SCIRQ_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wreq;
   assign card_irq = s_q.irq;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   irq_or_mask_a: assert property (@(posedge clk) disable iff (!nrst)
      card_irq == |(s_q.cause & s_q.mask))
      else $error("interrupt differs from cause and mask");

   mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
      (take && avs_write && idx == SCIRQ_IDX_MASK) |=> s_q.mask == $past(avs_writedata[7:0]))
      else $error("mask write lost");

   cause_rdclr_a: assert property (@(posedge clk) disable iff (!nrst)
      (take && avs_read && idx == SCIRQ_IDX_CAUSE && set_v == 8'h00)
      |=> (s_q.cause & $past(s_q.rdata[7:0]) & SCIRQ_CAUSE_RDCLR) == 8'h00)
      else $error("cause read did not clear");

   set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
      (set_v != 8'h00) |=> (s_q.cause & $past(set_v)) == $past(set_v))
      else $error("event lost");

   rx_level_a: assert property (@(posedge clk) disable iff (!nrst)
      (!s_q.bypass && !set_v[SCIRQ_B_RXAV]) |=> !s_q.cause[SCIRQ_B_RXAV])
      else $error("rx available not cleared by empty FIFO");

   card_event_a: assert property (@(posedge clk) disable iff (!nrst)
      (s_q.sel != SCIRQ_SEL_NONE && ev.card_detect_pin) |=> s_q.cause[SCIRQ_B_CARD])
      else $error("card event missed");

   txctl_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      (take && avs_read && idx == SCIRQ_IDX_TXCTL && set_v[3] == 1'b0 && set_v[1] == 1'b0)
      |=> !s_q.cause[SCIRQ_B_TXEVT] && !s_q.cause[SCIRQ_B_TX_ERROR_FLAG])
      else $error("tx control read did not clear");

   length_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (s_q.len_load == 8'h00) |-> !len_done)
      else $error("length counter ran with zero load");

   no_select_a: assert property (@(posedge clk) disable iff (!nrst)
      (s_q.sel == SCIRQ_SEL_NONE) |-> set_v == 8'h00)
      else $error("unselected interface raised a cause");

   answer_a: assert property (@(posedge clk) disable iff (!nrst)
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not in one cycle");

endmodule : scirq_top

`default_nettype wire

// ===== shared/scirq_pkg.sv
// Constants, field layout and state record of the smart card interrupt cause/mask block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses equal to four times
// each register index; the event sources sit outside this block.
//
// How it works
// - Cause read clears timeout, card, supply, sent bits
// - Only the selected interface feeds the cause bits
// - Async mode: bit 7 set on wait timeout
// - Sync mode: bit 7 set at length terminal count
// - Bit 6 set on card insert/remove or fault
// - Card event captured despite clock gate, power-down
// - Bit 5 set on supply timer expiry
// - Bit 4 follows receive FIFO not empty
// - Bypass: bit 4 set on data falling edge
// - Bit 3 on tx empty/full; tx-control read clears
// - Bit 2 set on each byte or check byte sent
// - Character protocol: no bit 2 on break-ended byte
// - Bit 1 on break or underrun; tx-control read clears
// - Bit 0 on overrun or parity; rx-control read clears
// - Mask bit gates its cause bit onto interrupt
// - Mask bits map one-to-one onto cause bits
// - Sync mode: mask bit 7 enables length interrupt
// - Select 00 none, 01 external, 1X internal
// - Length load 0 disables counting, 1..255 enables
package scirq_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] SCIRQ_IDX_SELECT = 16'hFE00;
   localparam logic [15:0] SCIRQ_IDX_CAUSE = 16'hFE01;
   localparam logic [15:0] SCIRQ_IDX_MASK = 16'hFE02;
   localparam logic [15:0] SCIRQ_IDX_MODE = 16'hFE10;
   localparam logic [15:0] SCIRQ_IDX_LENGTH = 16'hFE11;
   localparam logic [15:0] SCIRQ_IDX_TXCTL = 16'hFE12;
   localparam logic [15:0] SCIRQ_IDX_RXCTL = 16'hFE13;
   localparam int SCIRQ_ADDR_W = 18;

   // ---------------------------------------------------------------
   // Cause and mask bit positions
   // ---------------------------------------------------------------
   localparam int SCIRQ_B_TIMEOUT = 7;
   localparam int SCIRQ_B_CARD = 6;
   localparam int SCIRQ_B_SUPPLY = 5;
   localparam int SCIRQ_B_RXAV = 4;
   localparam int SCIRQ_B_TXEVT = 3;
   localparam int SCIRQ_B_TXDONE = 2;
   localparam int SCIRQ_B_TX_ERROR_FLAG = 1;
   localparam int SCIRQ_B_RX_ERROR_FLAG = 0;

   // Bits cleared by reads of the cause (bypass adds rx available), tx control and rx control registers
   localparam logic [7:0] SCIRQ_CAUSE_RDCLR = 8'hE4;
   localparam logic [7:0] SCIRQ_BYPASS_RDCLR = 8'h10;
   localparam logic [7:0] SCIRQ_TXCTL_CLR = 8'h0A;
   localparam logic [7:0] SCIRQ_RXCTL_CLR = 8'h01;

   // ---------------------------------------------------------------
   // Select register fields
   // ---------------------------------------------------------------
   localparam int SCIRQ_SEL_LSB = 2;
   localparam int SCIRQ_BYPASS_BIT = 1;
   localparam logic [1:0] SCIRQ_SEL_NONE = 2'h0;
   localparam logic [1:0] SCIRQ_SEL_EXT = 2'h1;

   // Mode register fields
   localparam int SCIRQ_MODE_SYNC = 0;
   localparam int SCIRQ_MODE_T0 = 1;
   localparam int SCIRQ_MODE_BRKEN = 2;

   // Reset values
   localparam logic [7:0] SCIRQ_CAUSE_RST = 8'h00;
   localparam logic [7:0] SCIRQ_MASK_RST = 8'h00;

   // ---------------------------------------------------------------
   // Event bundle from one card interface
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wait_timeout;
      logic card_detect_pin;
      logic fault;
      logic supply_stable_timer;
      logic rx_not_empty;
      logic tx_fifo_empty;
      logic tx_fifo_full;
      logic byte_sent;
      logic check_sent;
      logic break_at_end;
      logic break_detected;
      logic tx_underrun;
      logic rx_overrun;
      logic rx_parity;
      logic card_clk;
      logic card_data;
   } scirq_evt_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] cause;
      logic [7:0] mask;
      logic [1:0] sel;
      logic bypass;
      logic sync;
      logic t0;
      logic brk_en;
      logic [7:0] len_load;
      logic [7:0] len_cnt;
      logic len_run;
      logic clk_prev;
      logic dat_prev;
      logic txe_prev;
      logic txf_prev;
      logic brk_prev;
      logic und_prev;
      logic wreq;
      logic [31:0] rdata;
      logic irq;
   } scirq_state_t;

   localparam scirq_state_t SCIRQ_STATE_RST = '{cause: SCIRQ_CAUSE_RST, mask: SCIRQ_MASK_RST,
                                                wreq: 1'b1, default: '0};

endpackage : scirq_pkg

// ===== verif/scirq_top_tb.sv
// Self-checking bench for the smart card interrupt cause/mask block.
// Assumes the package register indices and a one-wait-state Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none

module scirq_top_tb;
   import scirq_pkg::*;

   // ----------------------------------------
   // Stimulus bit masks of the event bundle
   // ----------------------------------------
   localparam logic [15:0] ev_wto = 16'h8000, ev_cdet = 16'h4000, ev_flt = 16'h2000;
   localparam logic [15:0] ev_sup = 16'h1000, ev_rxne = 16'h0800, ev_txe = 16'h0400;
   localparam logic [15:0] ev_txf = 16'h0200, ev_sent = 16'h0100, ev_chk = 16'h0080;
   localparam logic [15:0] ev_brkend = 16'h0040, ev_brk = 16'h0020, ev_und = 16'h0010;
   localparam logic [15:0] ev_ovr = 16'h0008, ev_par = 16'h0004, ev_cclk = 16'h0002;
   localparam logic [15:0] ev_cdat = 16'h0001;

   logic clk, nrst, avs_read, avs_write, avs_waitrequest, gated, pwr_dn, card_irq;
   logic [SCIRQ_ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   scirq_evt_t evt_int, evt_ext;
   int n_errors, num_checks;

   always #4 clk = ~clk;

   scirq_top DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .evt_int(evt_int), .evt_ext(evt_ext),
      .logic_clk_gated(gated), .power_down_bit(pwr_dn), .card_irq(card_irq));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Request held until the edge that sees waitrequest low; data is taken at that edge
   task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
      int t;
      t = 0;
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 50);
      if (t >= 50) n_errors++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] q;
      xfer(idx, 1'b1, d, q);
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      xfer(idx, 1'b0, 8'h00, q);
      chk($sformatf("reg %h", idx), q, {24'h0, exp});
   endtask : rd

   // One cycle high on the chosen lines; the return to low gives falling edges too
   task automatic pulse(input logic [15:0] m, input logic to_int);
      @(posedge clk);
      if (to_int) evt_int <= m;
      else evt_ext <= m;
      @(posedge clk);
      evt_int <= '0;
      evt_ext <= '0;
      @(negedge clk);
   endtask : pulse

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {avs_read, avs_write, gated, pwr_dn} = '0;
      avs_address = '0;
      avs_writedata = '0;
      evt_int = '0;
      evt_ext = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      rd(SCIRQ_IDX_MASK, 8'h00);
      chk("irq", card_irq, 1'b0);
      rd(16'hFE30, 8'h00);
      wr(SCIRQ_IDX_SELECT, 8'h04);
      pulse(ev_sup, 1'b1);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_sup, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h20);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      wr(SCIRQ_IDX_SELECT, 8'h08);
      pulse(ev_sup, 1'b1);
      rd(SCIRQ_IDX_CAUSE, 8'h20);
      wr(SCIRQ_IDX_SELECT, 8'h00);
      pulse(ev_sup, 1'b1);
      pulse(ev_sup, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      wr(SCIRQ_IDX_SELECT, 8'h04);
      // Gated clock and power down keep only the card event
      wr(SCIRQ_IDX_MASK, 8'h40);
      rd(SCIRQ_IDX_MASK, 8'h40);
      gated <= 1'b1;
      pulse(ev_cdet | ev_sup, 1'b0);
      chk("irq", card_irq, 1'b1);
      rd(SCIRQ_IDX_CAUSE, 8'h40);
      @(negedge clk);
      chk("irq", card_irq, 1'b0);
      gated <= 1'b0;
      pwr_dn <= 1'b1;
      pulse(ev_flt, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h40);
      pwr_dn <= 1'b0;
      wr(SCIRQ_IDX_MASK, 8'hBF);
      pulse(ev_cdet, 1'b0);
      chk("irq", card_irq, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h40);
      // Receive data level is not cleared by reading
      @(posedge clk);
      evt_ext <= ev_rxne;
      rd(SCIRQ_IDX_CAUSE, 8'h10);
      rd(SCIRQ_IDX_CAUSE, 8'h10);
      evt_ext <= '0;
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_txe, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h08);
      rd(SCIRQ_IDX_CAUSE, 8'h08);
      wr(16'hFE30, 8'h00);
      rd(SCIRQ_IDX_TXCTL, 8'h00);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_txf | ev_brk, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h0A);
      rd(SCIRQ_IDX_TXCTL, 8'h00);
      pulse(ev_und, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h02);
      rd(SCIRQ_IDX_TXCTL, 8'h00);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_ovr, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h01);
      rd(SCIRQ_IDX_RXCTL, 8'h00);
      pulse(ev_par, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h01);
      rd(SCIRQ_IDX_RXCTL, 8'h00);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_chk, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h04);
      wr(SCIRQ_IDX_MODE, 8'h06);
      pulse(ev_sent | ev_brkend, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_sent, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h04);
      wr(SCIRQ_IDX_MODE, 8'h00);
      pulse(ev_wto, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h80);
      // Sync mode: length counter drives bit 7, a load of 0 never counts
      wr(SCIRQ_IDX_MODE, 8'h01);
      wr(SCIRQ_IDX_MASK, 8'h80);
      wr(SCIRQ_IDX_LENGTH, 8'h02);
      pulse(ev_cclk | ev_wto, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      pulse(ev_cclk, 1'b0);
      @(negedge clk);
      chk("irq", card_irq, 1'b1);
      rd(SCIRQ_IDX_CAUSE, 8'h80);
      wr(SCIRQ_IDX_LENGTH, 8'h00);
      repeat (3) pulse(ev_cclk, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h00);
      wr(SCIRQ_IDX_MODE, 8'h00);
      wr(SCIRQ_IDX_SELECT, 8'h06);
      pulse(ev_cdat, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h10);
      // Firmware masks the rx bit while it shifts a bypass byte in
      wr(SCIRQ_IDX_MASK, 8'hEF);
      pulse(ev_cdat, 1'b0);
      @(negedge clk);
      chk("irq", card_irq, 1'b0);
      rd(SCIRQ_IDX_CAUSE, 8'h10);
      summarize();
   end

   // Whole run is well under 2000 cycles; the limit leaves ample margin
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
endmodule : scirq_top_tb

`default_nettype wire
